//--- logic/clock_prescaler.sv
`timescale 1ns/1ns
module clock_prescaler
  import motor_timer_pkg::*;
#(
  parameter int DIV_BITS = PSC_DIV_BITS
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] psc_code,
  output logic tick
);

  logic [DIV_BITS-1:0] div_q;
  logic [DIV_BITS-1:0] div_d;
  logic [DIV_BITS:0] full_mask;
  logic [DIV_BITS-1:0] mask;

  // Mask of low bits that must all be one, 2^code cycles per tick
  assign full_mask = ({{DIV_BITS{1'b0}}, 1'b1} << psc_code) - 1'b1;
  assign mask = full_mask[DIV_BITS-1:0];
  assign tick = run && ((div_q & mask) == mask);
  assign div_d = run ? div_q + 1'b1 : '0;

  // Free divider, held at zero while stopped
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      div_q <= '0;
    else
      div_q <= div_d;
  end

endmodule : clock_prescaler

//--- logic/input_edge_filter.sv
`timescale 1ns/1ns
module input_edge_filter
  import motor_timer_pkg::*;
#(
  parameter int FILT_CYCLES = FILTER_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic filt_en,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic [2:0] sync_q;
  logic lvl_q;
  logic lvl_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic rise_q;
  logic fall_q;
  logic differ;
  logic filt_done;

  // Settled when the second and third stages agree
  assign differ = (sync_q[1] == sync_q[2]) && (sync_q[2] != lvl_q);
  assign filt_done = cnt_q == 3'(FILT_CYCLES - 2);

  // Short pulses are dropped while the filter is on
  always_comb
  begin
    lvl_d = lvl_q;
    cnt_d = 3'h0;
    if (differ && !filt_en)
      lvl_d = sync_q[2];
    else if (differ && filt_done)
      lvl_d = sync_q[2];
    else if (differ)
      cnt_d = cnt_q + 3'h1;
  end

  // Sync chain, level and edge pulses
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync_q <= 3'h0;
      lvl_q <= 1'b0;
      cnt_q <= 3'h0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      sync_q <= {sync_q[1:0], pin};
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
      rise_q <= lvl_d && !lvl_q;
      fall_q <= !lvl_d && lvl_q;
    end
  end

  assign level = lvl_q;
  assign rise = rise_q;
  assign fall = fall_q;

endmodule : input_edge_filter

//--- logic/motor_timer_pkg.sv
package motor_timer_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'ha1;
  localparam logic [7:0] ADDR_CTRL_FLAGS = 8'ha9;
  localparam logic [7:0] ADDR_COUNTER_LO = 8'haa;
  localparam logic [7:0] ADDR_COUNTER_HI = 8'hab;
  localparam logic [7:0] ADDR_CMPCAP_LO = 8'hac;
  localparam logic [7:0] ADDR_CMPCAP_HI = 8'had;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'hae;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'haf;
  localparam logic [7:0] ADDR_STEP_FILT = 8'hf9;

  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Config field positions
  localparam int PSC_MSB = 7;
  localparam int PSC_LSB = 5;
  localparam int POL_BIT = 4;
  localparam int IRE_BIT = 3;
  localparam int CES_BIT = 2;
  localparam int MODE_MSB = 1;

  // Control/flag field positions
  localparam int IR_BIT = 7;
  localparam int IP_BIT = 6;
  localparam int IF_BIT = 5;
  localparam int IPE_BIT = 4;
  localparam int IFE_BIT = 3;
  localparam int FE_BIT = 2;
  localparam int DIR_BIT = 1;
  localparam int EN_BIT = 0;

  // Stepper input select position
  localparam int SS_BIT = 7;

  // Counts
  localparam logic [15:0] TIMER_MAX = 16'hffff;
  localparam int FILTER_CYCLES = 4;
  localparam int PSC_DIV_BITS = 7;

  typedef enum logic [1:0]
  {
    MODE_CAPTURE = 2'b00,
    MODE_OUTPUT = 2'b01,
    MODE_COUNT = 2'b10,
    MODE_DECODE = 2'b11
  } mode_e;

endpackage : motor_timer_pkg

//--- logic/multimode_motor_timer.sv
`timescale 1ns/1ns
// Behaviour
// - Three-bit prescaler divides the clock by 1 up to 128.
// - Two-bit mode: capture, output/PWM, pulse counting, decoder.
// - Output low while counter <= compare, high above; polarity inverts.
// - In decoder mode polarity bit picks quadrature (0) or stepper (1).
// - Capture select 0: rising period, high width; 1: falling, low width.
// - Counting and stepper: edge-select 0 counts falling, 1 rising edges.
// - Quadrature: edge-select 1 lets the zero marker clear the position.
// - On that zero marker the position is copied to the data register.
// - First enable gates match, pulse-width or direction-change flag.
// - Output mode sets the match flag on counter equal compare.
// - Capture sets width flag on width and cycle flag on period.
// - Cycle flag on count match in counting, on active edge in decoder.
// - Output mode: counter equal reload sets overflow and clears counter.
// - Capture and counting: base timer at 0xffff sets overflow, clears.
// - Decoder modes: base timer at 0xffff sets overflow, clears itself.
// - Cycle and overflow enables gate their flags.
// - Filter enable rejects input pulses narrower than four clocks.
// - Read-only direction bit: 0 forward, 1 backward.
// - Timer counts only while enable is one.
// - Stepper select: direction plus pulse, or forward and reverse pulses.
// - Counter register shows base timer, or position in decoder mode.
// - Reload register loaded with period, match time or edge time.
// - Capture loads the data register with the measured width.
// - Position counts up forward and down reverse on active edges.
module multimode_motor_timer
  import motor_timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic step_pulse_pin,
  input wire logic direction_pin,
  input wire logic zero_marker_interrupt,
  output logic pwm_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0] cfg_q;
  logic match_width_dirchange_flag_q;
  logic cycle_edge_flag_q;
  logic overflow_flag_q;
  logic cycle_irq_enable_q;
  logic overflow_irq_enable_q;
  logic noise_filter_enable_q;
  logic rotation_direction_q;
  logic timer_enable_q;
  logic stepper_input_select_q;
  logic [15:0] base_q;
  logic [15:0] base_d;
  logic [15:0] pos_q;
  logic [15:0] pos_d;
  logic [15:0] dr_q;
  logic [15:0] dr_d;
  logic [15:0] dr_pre_q;
  logic dr_hi_pending_q;
  logic [15:0] arr_q;
  logic [15:0] arr_d;
  logic [15:0] pulse_tally_q;
  logic [15:0] pulse_tally_d;
  logic armed_q;
  logic armed_d;
  logic dir_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic pwm_q;
  logic pwm_d;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  mode_e mode;
  logic polarity;
  logic edge_sel;
  logic quad_sel;
  logic step_sel;
  assign mode = mode_e'(cfg_q[MODE_MSB:0]);
  assign polarity = cfg_q[POL_BIT];
  assign edge_sel = cfg_q[CES_BIT];
  assign quad_sel = (mode == MODE_DECODE) && !polarity;
  assign step_sel = (mode == MODE_DECODE) && polarity;

  // Bus write decode
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_dr_lo;
  logic wr_dr_hi;
  logic wr_arr_lo;
  logic wr_arr_hi;
  logic wr_ss;
  assign wr_cfg = wr_stb && (addr == ADDR_CONFIG);
  assign wr_ctrl = wr_stb && (addr == ADDR_CTRL_FLAGS);
  assign wr_cnt_lo = wr_stb && (addr == ADDR_COUNTER_LO);
  assign wr_cnt_hi = wr_stb && (addr == ADDR_COUNTER_HI);
  assign wr_dr_lo = wr_stb && (addr == ADDR_CMPCAP_LO);
  assign wr_dr_hi = wr_stb && (addr == ADDR_CMPCAP_HI);
  assign wr_arr_lo = wr_stb && (addr == ADDR_RELOAD_LO);
  assign wr_arr_hi = wr_stb && (addr == ADDR_RELOAD_HI);
  assign wr_ss = wr_stb && (addr == ADDR_STEP_FILT);

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and input conditioning

  logic tick;
  clock_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(timer_enable_q),
    .psc_code(cfg_q[PSC_MSB:PSC_LSB]),
    .tick(tick)
  );

  // Channel 0 pulse / A, 1 direction / B, 2 zero marker
  logic [2:0] in_pins;
  logic [2:0] in_lvl;
  logic [2:0] in_rise;
  logic [2:0] in_fall;
  assign in_pins = {zero_marker_interrupt, direction_pin, step_pulse_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_in
      input_edge_filter u_filt (
        .ref_clk(ref_clk),
        .rst(rst),
        .filt_en(noise_filter_enable_q),
        .pin(in_pins[gi]),
        .level(in_lvl[gi]),
        .rise(in_rise[gi]),
        .fall(in_fall[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Edge events per mode

  logic run;
  logic a_act;
  logic cap_start;
  logic cap_width;
  logic quad_edge;
  logic quad_fwd;
  logic step_edge;
  logic step_back;
  logic dec_edge;
  logic dec_back;
  logic zero_clear;
  logic tally_hit;
  logic [15:0] tally_inc;
  logic base_top;
  logic arr_hit;
  assign run = timer_enable_q;
  // Active edge of the pulse input chosen by edge select
  assign a_act = edge_sel ? in_rise[0] : in_fall[0];
  // Period edge and width-end edge in capture mode
  assign cap_start = edge_sel ? in_fall[0] : in_rise[0];
  assign cap_width = edge_sel ? in_rise[0] : in_fall[0];
  // Four-edge quadrature decode
  assign quad_edge = in_rise[0] | in_fall[0] | in_rise[1] | in_fall[1];
  assign quad_fwd = (in_rise[0] && !in_lvl[1]) || (in_fall[0] && in_lvl[1])
    || (in_rise[1] && in_lvl[0]) || (in_fall[1] && !in_lvl[0]);
  // Stepper: direction plus pulse, or forward and reverse pulse pins
  assign step_edge = stepper_input_select_q
    ? (a_act || (edge_sel ? in_rise[1] : in_fall[1])) : a_act;
  assign step_back = stepper_input_select_q ? !a_act : in_lvl[1];
  assign dec_edge = run && (quad_sel ? quad_edge : step_edge);
  assign dec_back = quad_sel ? !quad_fwd : step_back;
  assign zero_clear = run && quad_sel && edge_sel && in_rise[2];
  assign tally_inc = pulse_tally_q + 16'h0001;
  assign tally_hit = run && a_act && (tally_inc == dr_q);
  assign base_top = base_q == TIMER_MAX;
  assign arr_hit = base_q == arr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Timer, capture and decoder datapath

  logic ev_ir;
  logic ev_ip;
  logic ev_if;
  always_comb
  begin
    base_d = base_q;
    pos_d = pos_q;
    arr_d = arr_q;
    dr_d = dr_q;
    pulse_tally_d = pulse_tally_q;
    armed_d = armed_q;
    dir_d = rotation_direction_q;
    ev_ir = 1'b0;
    ev_ip = 1'b0;
    ev_if = 1'b0;
    case (mode)
      MODE_OUTPUT:
      begin
        if (tick && arr_hit)
        begin
          ev_if = 1'b1;
          base_d = WORD_RESET;
        end
        else if (tick)
          base_d = base_q + 16'h0001;
        ev_ir = tick && (base_q == dr_q);
      end
      MODE_CAPTURE:
      begin
        if (tick && base_top)
        begin
          ev_if = 1'b1;
          base_d = WORD_RESET;
        end
        else if (tick)
          base_d = base_q + 16'h0001;
        if (run && cap_width && armed_q)
        begin
          dr_d = base_q;
          ev_ir = 1'b1;
        end
        if (run && cap_start)
        begin
          if (armed_q)
          begin
            arr_d = base_q;
            ev_ip = 1'b1;
          end
          armed_d = 1'b1;
          base_d = WORD_RESET;
        end
      end
      MODE_COUNT:
      begin
        if (tick && base_top)
        begin
          ev_if = 1'b1;
          base_d = WORD_RESET;
        end
        else if (tick)
          base_d = base_q + 16'h0001;
        if (run && a_act)
          pulse_tally_d = tally_inc;
        if (run && a_act && !armed_q)
        begin
          armed_d = 1'b1;
          base_d = WORD_RESET;
        end
        if (tally_hit)
        begin
          arr_d = base_q;
          ev_ip = 1'b1;
          base_d = WORD_RESET;
          pulse_tally_d = WORD_RESET;
        end
      end
      default:
      begin
        if (tick && base_top)
        begin
          ev_if = 1'b1;
          base_d = WORD_RESET;
        end
        else if (tick)
          base_d = base_q + 16'h0001;
        if (dec_edge)
        begin
          pos_d = dec_back ? pos_q - 16'h0001 : pos_q + 16'h0001;
          arr_d = base_q;
          base_d = WORD_RESET;
          ev_ip = 1'b1;
          dir_d = dec_back;
          ev_ir = dec_back != rotation_direction_q;
        end
        if (zero_clear)
        begin
          dr_d = pos_q;
          pos_d = WORD_RESET;
        end
      end
    endcase
    // Software writes to the counter word
    if (wr_cnt_lo && (mode == MODE_DECODE))
      pos_d = {pos_q[15:8], wdata};
    if (wr_cnt_hi && (mode == MODE_DECODE))
      pos_d = {wdata, pos_q[7:0]};
    if (wr_cnt_lo && (mode != MODE_DECODE))
      base_d = {base_q[15:8], wdata};
    if (wr_cnt_hi && (mode != MODE_DECODE))
      base_d = {wdata, base_q[7:0]};
    if (wr_arr_lo)
      arr_d = {arr_q[15:8], wdata};
    if (wr_arr_hi)
      arr_d = {wdata, arr_q[7:0]};
    // Counting mode uses the preload copy, others take writes at once
    if ((mode != MODE_COUNT) && wr_dr_lo)
      dr_d = {dr_q[15:8], wdata};
    if ((mode != MODE_COUNT) && wr_dr_hi)
      dr_d = {wdata, dr_q[7:0]};
    if ((mode == MODE_COUNT) && !dr_hi_pending_q
        && (ev_ip || ev_if || !run))
      dr_d = dr_pre_q;
    if (!run)
      armed_d = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag set and clear, set wins over a clearing write

  logic set_ir;
  logic set_ip;
  logic set_if;
  logic clr_ir;
  logic clr_ip;
  logic clr_if;
  assign set_ir = ev_ir && cfg_q[IRE_BIT];
  assign set_ip = ev_ip && cycle_irq_enable_q;
  assign set_if = ev_if && overflow_irq_enable_q;
  assign clr_ir = wr_ctrl && !wdata[IR_BIT];
  assign clr_ip = wr_ctrl && !wdata[IP_BIT];
  assign clr_if = wr_ctrl && !wdata[IF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // PWM level and read mux

  logic [15:0] cnt_view;
  assign cnt_view = (mode == MODE_DECODE) ? pos_q : base_q;
  assign pwm_d = (mode == MODE_OUTPUT)
    ? ((base_q <= dr_q) ? polarity : !polarity) : 1'b0;

  always_comb
  begin
    rdata_d = 8'h00;
    if (rd_stb)
    begin
      case (addr)
        ADDR_CONFIG: rdata_d = cfg_q;
        ADDR_CTRL_FLAGS: rdata_d = {match_width_dirchange_flag_q,
          cycle_edge_flag_q, overflow_flag_q, cycle_irq_enable_q,
          overflow_irq_enable_q, noise_filter_enable_q,
          rotation_direction_q, timer_enable_q};
        ADDR_COUNTER_LO: rdata_d = cnt_view[7:0];
        ADDR_COUNTER_HI: rdata_d = cnt_view[15:8];
        ADDR_CMPCAP_LO: rdata_d = dr_q[7:0];
        ADDR_CMPCAP_HI: rdata_d = dr_q[15:8];
        ADDR_RELOAD_LO: rdata_d = arr_q[7:0];
        ADDR_RELOAD_HI: rdata_d = arr_q[15:8];
        ADDR_STEP_FILT: rdata_d = {stepper_input_select_q, 7'h00};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg_q <= CONFIG_RESET;
      cycle_irq_enable_q <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
      noise_filter_enable_q <= 1'b0;
      timer_enable_q <= 1'b0;
      stepper_input_select_q <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= wdata;
      if (wr_ctrl)
      begin
        cycle_irq_enable_q <= wdata[IPE_BIT];
        overflow_irq_enable_q <= wdata[IFE_BIT];
        noise_filter_enable_q <= wdata[FE_BIT];
        timer_enable_q <= wdata[EN_BIT];
      end
      if (wr_ss)
        stepper_input_select_q <= wdata[SS_BIT];
    end
  end

  // Flags, preload and status
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      match_width_dirchange_flag_q <= 1'b0;
      cycle_edge_flag_q <= 1'b0;
      overflow_flag_q <= 1'b0;
      rotation_direction_q <= 1'b0;
      dr_pre_q <= WORD_RESET;
      dr_hi_pending_q <= 1'b0;
    end
    else
    begin
      match_width_dirchange_flag_q <= set_ir ||
        (match_width_dirchange_flag_q && !clr_ir);
      cycle_edge_flag_q <= set_ip || (cycle_edge_flag_q && !clr_ip);
      overflow_flag_q <= set_if || (overflow_flag_q && !clr_if);
      rotation_direction_q <= dir_d;
      if (wr_dr_hi)
      begin
        dr_pre_q[15:8] <= wdata;
        dr_hi_pending_q <= 1'b1;
      end
      if (wr_dr_lo)
      begin
        dr_pre_q[7:0] <= wdata;
        dr_hi_pending_q <= 1'b0;
      end
    end
  end

  // Counters and data words
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      base_q <= WORD_RESET;
      pos_q <= WORD_RESET;
      dr_q <= WORD_RESET;
      arr_q <= WORD_RESET;
      pulse_tally_q <= WORD_RESET;
      armed_q <= 1'b0;
      rdata_q <= 8'h00;
      pwm_q <= 1'b0;
    end
    else
    begin
      base_q <= base_d;
      pos_q <= pos_d;
      dr_q <= dr_d;
      arr_q <= arr_d;
      pulse_tally_q <= pulse_tally_d;
      armed_q <= armed_d;
      rdata_q <= rdata_d;
      pwm_q <= pwm_d;
    end
  end

  assign rdata = rdata_q;
  assign pwm_out = pwm_q;

endmodule : multimode_motor_timer

//--- sim/encoder_model.sv
`timescale 1ns/1ns
module encoder_model
(
  input wire logic ref_clk,
  output logic step_pulse_pin,
  output logic direction_pin,
  output logic zero_marker_interrupt
);
  logic [1:0] ph;
  // Lines idle low
  initial
    {step_pulse_pin, direction_pin, zero_marker_interrupt, ph} = '0;
  ////////////////////////////////////////////////////////////////////////////
  // One high pulse on either line
  task pulse(input logic sel, input int hi, input int lo);
    {direction_pin, step_pulse_pin} <= sel ? 2'b10 : 2'b01;
    repeat (hi) @(posedge ref_clk);
    {direction_pin, step_pulse_pin} <= 2'b00;
    repeat (lo) @(posedge ref_clk);
  endtask : pulse
  // One Gray-code step, A leading forward
  task quad(input logic fwd);
    ph = fwd ? ph + 2'd1 : ph - 2'd1;
    {step_pulse_pin, direction_pin} <= {ph[1] ^ ph[0], ph[1]};
    repeat (10) @(posedge ref_clk);
  endtask : quad
  // Zero marker pulse
  task zmark;
    zero_marker_interrupt <= 1'b1;
    repeat (8) @(posedge ref_clk);
    zero_marker_interrupt <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : zmark
endmodule : encoder_model

//--- sim/multimode_motor_timer_properties.sv
`timescale 1ns/1ns
module motor_timer_checker
  import motor_timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic pwm_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] cfg_q;
  logic en_q;
  logic mapped;
  // Address map decode
  assign mapped = addr inside {ADDR_CONFIG, ADDR_CTRL_FLAGS,
    [ADDR_COUNTER_LO:ADDR_RELOAD_HI], ADDR_STEP_FILT};
  // Shadow of mode and enable as written
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg_q <= 8'h00;
      en_q <= 1'b0;
    end
    else if (wr_stb && addr == ADDR_CONFIG)
      cfg_q <= wdata;
    else if (wr_stb && addr == ADDR_CTRL_FLAGS)
      en_q <= wdata[EN_BIT];
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data not zero when idle");
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst |=> rdata == 8'h00 && !pwm_out)
    else $error("outputs not quiet after reset");
  chk_unmapped_zero: assert property (rd_stb && !mapped |=>
    rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_config_back: assert property (wr_stb && addr == ADDR_CONFIG ##1
    rd_stb && addr == ADDR_CONFIG |=> rdata == $past(wdata, 2))
    else $error("config readback wrong");
  chk_ctrl_back: assert property (wr_stb && addr == ADDR_CTRL_FLAGS ##1
    rd_stb && addr == ADDR_CTRL_FLAGS |=> rdata[4:2] == $past(wdata[4:2], 2)
    && rdata[0] == $past(wdata[0], 2))
    else $error("control readback wrong");
  chk_step_back: assert property (wr_stb && addr == ADDR_STEP_FILT ##1
    rd_stb && addr == ADDR_STEP_FILT |=> rdata == {$past(wdata[7], 2), 7'h00})
    else $error("stepper select readback wrong");
  chk_pwm_quiet: assert property (cfg_q[1:0] != MODE_OUTPUT &&
    $past(cfg_q[1:0]) != MODE_OUTPUT |-> !pwm_out)
    else $error("output active outside output mode");
  chk_count_back: assert property (wr_stb && addr == ADDR_COUNTER_LO &&
    !en_q && cfg_q[1:0] == MODE_OUTPUT ##1 rd_stb && addr == ADDR_COUNTER_LO
    |=> rdata == $past(wdata, 2))
    else $error("stopped counter readback wrong");
endmodule : motor_timer_checker

bind multimode_motor_timer motor_timer_checker chk_u (.ref_clk(ref_clk),
  .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .pwm_out(pwm_out));

//--- sim/multimode_motor_timer_test.sv
`timescale 1ns/1ns
`define CHECK(nm, ex, gt) \
  begin \
    compares++; \
    if ((gt) !== (ex)) \
    begin \
      err_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module multimode_motor_timer_test;
  import motor_timer_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic step_pulse_pin;
  logic direction_pin;
  logic zero_marker_interrupt;
  logic pwm_out;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic [15:0] v;
  logic [15:0] w;
  always #10 ref_clk = ~ref_clk;
  multimode_motor_timer dut_u (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .step_pulse_pin(step_pulse_pin), .direction_pin(direction_pin),
    .zero_marker_interrupt(zero_marker_interrupt), .pwm_out(pwm_out));
  encoder_model enc_u (.ref_clk(ref_clk), .step_pulse_pin(step_pulse_pin),
    .direction_pin(direction_pin),
    .zero_marker_interrupt(zero_marker_interrupt));
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // Register bus cycles
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task idle(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(posedge ref_clk);
    d = rdata;
  endtask : rd
  task wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a + 8'h01, d[15:8]);
    wr(a, d[7:0]);
  endtask : wr16
  task rd16(input logic [7:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
  endtask : rd16
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    logic [7:0] amap [9];
    amap = '{ADDR_CONFIG, ADDR_CTRL_FLAGS, ADDR_COUNTER_LO, ADDR_COUNTER_HI,
      ADDR_CMPCAP_LO, ADDR_CMPCAP_HI, ADDR_RELOAD_LO, ADDR_RELOAD_HI,
      ADDR_STEP_FILT};
    foreach (amap[i])
    begin
      rd(amap[i], rv);
      `CHECK("reset value", 8'h00, rv)
    end
    wr(ADDR_CONFIG, 8'hb6);
    rd(ADDR_CONFIG, rv);
    `CHECK("config", 8'hb6, rv)
    wr(ADDR_STEP_FILT, 8'hff);
    rd(ADDR_STEP_FILT, rv);
    `CHECK("step select", 8'h80, rv)
    wr(ADDR_CTRL_FLAGS, 8'he4);
    rd(ADDR_CTRL_FLAGS, rv);
    `CHECK("flag write one", 8'h04, rv)
    rd(8'h00, rv);
    wr(ADDR_CONFIG, 8'h01);
    wr16(ADDR_COUNTER_LO, 16'h1234);
    rd16(ADDR_COUNTER_LO, v);
    `CHECK("counter", 16'h1234, v)
    $display("t_regs done");
  endtask : t_regs
  task t_psc;
    int exp;
    wr16(ADDR_RELOAD_LO, 16'hffff);
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_CTRL_FLAGS, 8'h00);
      wr16(ADDR_COUNTER_LO, 16'h0000);
      wr(ADDR_CONFIG, {c[2:0], 5'h01});
      wr(ADDR_CTRL_FLAGS, 8'h01);
      idle(256);
      wr(ADDR_CTRL_FLAGS, 8'h00);
      rd16(ADDR_COUNTER_LO, v);
      exp = 256 >> c;
      `CHECK("prescale", 1'b1, v + 2 >= exp && v <= exp + 2)
      idle(20);
      rd16(ADDR_COUNTER_LO, w);
      `CHECK("stopped hold", v, w)
    end
    $display("t_psc done");
  endtask : t_psc
  task t_output;
    int hi;
    hi = 0;
    wr16(ADDR_CMPCAP_LO, 16'h0003);
    wr16(ADDR_RELOAD_LO, 16'h0009);
    wr16(ADDR_COUNTER_LO, 16'h0000);
    wr(ADDR_CONFIG, 8'h09);
    wr(ADDR_CTRL_FLAGS, 8'h09);
    idle(1);
    repeat (40)
    begin
      @(posedge ref_clk);
      hi += pwm_out;
    end
    `CHECK("pwm duty", 1'b1, hi >= 22 && hi <= 26)
    wr(ADDR_CTRL_FLAGS, 8'he8);
    rd(ADDR_CTRL_FLAGS, rv);
    `CHECK("output flags", 8'ha8, rv)
    wr(ADDR_CTRL_FLAGS, 8'h08);
    rd(ADDR_CTRL_FLAGS, rv);
    `CHECK("flag clear", 8'h08, rv)
    rd16(ADDR_COUNTER_LO, v);
    `CHECK("pwm level", v > 16'h0003, pwm_out)
    wr(ADDR_CONFIG, 8'h19);
    idle(3);
    `CHECK("pwm inverted", v <= 16'h0003, pwm_out)
    wr(ADDR_CONFIG, 8'h11);
    wr(ADDR_CTRL_FLAGS, 8'h01);
    idle(30);
    wr(ADDR_CTRL_FLAGS, 8'he0);
    rd(ADDR_CTRL_FLAGS, rv);
    `CHECK("gated flags", 8'h00, rv)
    $display("t_output done");
  endtask : t_output
  task t_capture;
    for (int e = 0; e < 2; e++)
    begin
      wr(ADDR_CTRL_FLAGS, 8'h00);
      wr(ADDR_CONFIG, e ? 8'h0c : 8'h08);
      wr(ADDR_CTRL_FLAGS, 8'h19);
      idle(1);
      repeat (3) enc_u.pulse(1'b0, 20, 30);
      wr(ADDR_CTRL_FLAGS, 8'hf8);
      rd(ADDR_CTRL_FLAGS, rv);
      `CHECK("capture flags", 8'hd8, rv)
      rd16(ADDR_CMPCAP_LO, v);
      w = e ? 16'd30 : 16'd20;
      `CHECK("width", 1'b1, v + 16'd1 >= w && v <= w + 16'd1)
      rd16(ADDR_RELOAD_LO, v);
      `CHECK("period", 1'b1, v >= 16'd49 && v <= 16'd51)
    end
    $display("t_capture done");
  endtask : t_capture
  task t_count;
    wr(ADDR_CTRL_FLAGS, 8'h00);
    wr(ADDR_CONFIG, 8'h06);
    wr16(ADDR_CMPCAP_LO, 16'h0003);
    wr(ADDR_CTRL_FLAGS, 8'h11);
    idle(1);
    repeat (2) enc_u.pulse(1'b0, 10, 10);
    rd(ADDR_CTRL_FLAGS, rv);
    `CHECK("count pending", 8'h11, rv)
    enc_u.pulse(1'b0, 10, 10);
    rd(ADDR_CTRL_FLAGS, rv);
    `CHECK("count match", 8'h51, rv)
    $display("t_count done");
  endtask : t_count
  task t_decode;
    wr(ADDR_CTRL_FLAGS, 8'h00);
    wr(ADDR_CONFIG, 8'h0f);
    wr(ADDR_CTRL_FLAGS, 8'h11);
    idle(1);
    enc_u.zmark();
    repeat (8) enc_u.quad(1'b1);
    rd(ADDR_CTRL_FLAGS, rv);
    `CHECK("edge flag", 1'b1, rv[6])
    rd16(ADDR_COUNTER_LO, v);
    `CHECK("position fwd", 16'h0008, v)
    repeat (3) enc_u.quad(1'b0);
    rd(ADDR_CTRL_FLAGS, rv);
    `CHECK("dir change", 2'b11, {rv[7], rv[1]})
    enc_u.zmark();
    rd16(ADDR_CMPCAP_LO, w);
    rd16(ADDR_COUNTER_LO, v);
    `CHECK("zero copy", 16'h0005, w)
    `CHECK("zero clear", 16'h0000, v)
    wr(ADDR_CONFIG, 8'h0b);
    idle(1);
    enc_u.quad(1'b1);
    enc_u.zmark();
    rd16(ADDR_COUNTER_LO, v);
    `CHECK("zero ignored", 16'h0001, v)
    $display("t_decode done");
  endtask : t_decode
  task t_step;
    wr(ADDR_STEP_FILT, 8'h00);
    wr(ADDR_CONFIG, 8'h17);
    wr(ADDR_CTRL_FLAGS, 8'h01);
    idle(1);
    enc_u.pulse(1'b0, 6, 6);
    rd16(ADDR_COUNTER_LO, w);
    repeat (4) enc_u.pulse(1'b0, 6, 6);
    rd16(ADDR_COUNTER_LO, v);
    `CHECK("step forward", w + 16'd4, v)
    wr(ADDR_CTRL_FLAGS, 8'h05);
    idle(1);
    enc_u.pulse(1'b0, 3, 10);
    rd16(ADDR_COUNTER_LO, v);
    `CHECK("glitch filtered", w + 16'd4, v)
    wr(ADDR_CTRL_FLAGS, 8'h01);
    idle(1);
    enc_u.pulse(1'b0, 2, 10);
    rd16(ADDR_COUNTER_LO, v);
    `CHECK("glitch passed", w + 16'd5, v)
    wr(ADDR_STEP_FILT, 8'h80);
    idle(1);
    repeat (2) enc_u.pulse(1'b1, 6, 6);
    rd16(ADDR_COUNTER_LO, v);
    `CHECK("reverse pulses", w + 16'd3, v)
    $display("t_step done");
  endtask : t_step
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_psc();
    t_output();
    t_capture();
    t_count();
    t_decode();
    t_step();
    idle(2);
    tally_and_finish();
  end
endmodule : multimode_motor_timer_test
